// [core/fpc_pkg.sv]
// fpc_pkg: register map, field positions, codes and types of the
// format parameter list checker.
// assumes: one 10 MHz clock, classic Wishbone register access.
package fpc_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_DATA = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_MAXCYL = 8'h0C;
    localparam logic [7:0] A_GEOM = 8'h10;
    localparam logic [7:0] A_BPT = 8'h14;
    localparam logic [7:0] A_BLKSZ = 8'h18;
    localparam logic [7:0] A_PLWR = 8'h1C;
    localparam logic [7:0] A_GLIDX = 8'h20;
    localparam logic [7:0] A_GLDAT = 8'h24;
    localparam logic [7:0] A_GLCNT = 8'h28;
    // control word
    localparam int C_START = 0;
    localparam int C_FMT_DATA = 1;
    localparam int C_LFMT = 2;
    // parameter list header byte 1
    localparam int H_PRIM_DIS = 6;
    localparam int H_PAT_INC = 3;
    localparam int H_DSP = 2;
    localparam int H_IMMED = 1;
    // pattern descriptor byte 0
    localparam int P_SI = 5;
    localparam int P_MOD = 6;
    localparam logic [1:0] HDR_LAST = 2'h3;
    localparam logic [2:0] DSC_LAST = 3'h7;
    localparam logic [2:0] LF_BLOCK = 3'h0;
    localparam logic [2:0] LF_BFI = 3'h4;
    localparam logic [2:0] LF_PHYS = 3'h5;
    localparam logic [7:0] PT_DEFAULT = 8'h00;
    localparam logic [7:0] PT_USER = 8'h01;
    localparam logic [15:0] DLL_MAX = 16'h2000;
    localparam logic [10:0] HL_MAX = 11'h400;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [3:0] SK_MEDIUM = 4'h3;
    localparam logic [7:0] ASC_INVAL_PL = 8'h26;
    localparam logic [7:0] ASC_FMT_FAIL = 8'h31;
    localparam logic [7:0] FILL_ZERO = 8'h00;
    localparam logic [7:0] FILL_DEFAULT = 8'h00;
    localparam logic [23:0] MAXCYL_RST = 24'h00FFFF;
    localparam logic [7:0] HEADS_RST = 8'h10;
    localparam logic [15:0] SPT_RST = 16'h0100;
    localparam logic [31:0] BPT_RST = 32'h00100000;
    localparam logic [15:0] BLKSZ_RST = 16'h1000;
    typedef struct packed {
        logic prim_dis;
        logic pat_inc;
        logic dsp;
        logic immed;
    } fpc_opts_t;
    localparam fpc_opts_t OPTS_RST = 4'h2;
    typedef struct packed {
        logic check;
        logic defer;
        logic [3:0] key;
        logic [7:0] asc;
    } fpc_sense_t;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_HDR = 9'h002,
        ST_PHDR = 9'h004,
        ST_PAT = 9'h008,
        ST_DEF = 9'h010,
        ST_CHECK = 9'h020,
        ST_COMMIT = 9'h040,
        ST_FORMAT = 9'h080,
        ST_DONE = 9'h100
    } fpc_state_t;
endpackage

// [core/fpc_checker.sv]
// fpc_checker: receives and checks the format parameter list, builds the
// grown defect list and starts the media format engine.
// assumes: software streams list bytes over Wishbone; media engine on clk.
// What the document requires of this block
// RULE1 - initiator sends pattern modifier zero; the pattern is used unaltered
// RULE2 - secure bit set: every sector incl. reassigned; clear: accessible only
// RULE3 - type 0 uses default fill; type 1 repeats supplied bytes per block (here: repeats from format start, not restarted per block)
// RULE4 - pattern length, big-endian, non-zero and not above block size
// RULE5 - type 0 with non-zero length: check condition, invalid field
// RULE6 - type 1 with zero length: check condition, invalid field
// RULE7 - save-disable clear saves savable parameters; set leaves them unsaved
// RULE8 - immediate set: status after transfer; clear: after format ends
// RULE9 - immediate format ending in error produces deferred error sense
// RULE10 - defect length counts descriptor bytes only; at most 1024 entries
// RULE11 - defect length must be a whole multiple of descriptor size
// RULE12 - descriptors accepted in any order
// RULE13 - entry outside user-addressable media: check condition, invalid field
// RULE14 - block format 000b is not supported
// RULE15 - 100b: cylinder, head, byte from index; that byte's sector defective
// RULE16 - 101b: cylinder, head, sector number names one defective sector
// RULE17 - primary disabled: entry equal to primary entry skips grown list
// RULE18 - defect list only sent with format data set, in chosen layout
// RULE19 - pattern-included clear: zero fill; set: descriptor follows header
// RULE20 - primary disabled: primary list unused but kept intact
// RULE21 - every check finishes before any list or media change
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module fpc_checker
    import fpc_pkg::*;
#(
    parameter int PAT_DEPTH = 64,
    parameter int PL_DEPTH = 16,
    parameter int SECT_SHIFT = 12
) (
    input logic clk,
    input logic rst_b,
    input logic wb_cyc,
    input logic wb_stb,
    input logic wb_we,
    input logic [7:0] wb_adr,
    input logic [3:0] wb_sel,
    input logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input logic med_done,
    input logic med_err,
    input logic med_fill_next,
    output logic med_start,
    output logic med_si,
    output logic med_save,
    output logic med_pl_use,
    output logic [7:0] med_fill
);
    localparam int PW = $clog2(PAT_DEPTH);
    localparam int LW = $clog2(PL_DEPTH);

    generate
        if (PAT_DEPTH < 2 || PAT_DEPTH > 32768 || PL_DEPTH < 2 || SECT_SHIFT > 31) begin : g_bad
            $error("fpc_checker: parameter out of range");
        end
    endgenerate

    fpc_state_t st_ff, nxt_st;
    fpc_opts_t opts_ff;
    fpc_sense_t sense_ff;
    logic wb_ack_ff, ready_ff, fmt_data_ff, si_ff, med_start_ff, med_save_ff, inval_ff;
    logic pl_use_ff;
    logic [31:0] wb_dat_r_ff;
    logic [2:0] lfmt_ff;
    logic [7:0] ptype_ff, heads_ff, fill_ff;
    logic [15:0] cnt_ff, dll_ff, plen_ff, spt_ff, blksz_ff, fptr_ff;
    logic [23:0] maxcyl_ff;
    logic [31:0] bpt_ff;
    logic [55:0] dsr_ff;
    logic [9:0] gl_idx_ff;
    logic [10:0] hl_cnt_ff, gl_cnt_ff;
    logic [LW:0] pl_cnt_ff;
    logic [7:0] pat_mem [PAT_DEPTH];
    logic [31:0] pl_mem [PL_DEPTH];
    logic [31:0] hl_mem [1024];
    logic [31:0] gl_mem [1024];

    // bus decode
    wire req = wb_cyc & wb_stb & ~wb_ack_ff;
    wire wr = req & wb_we & wb_sel[0];
    wire [7:0] db = wb_dat_w[7:0];
    wire data_we = wr & (wb_adr == A_DATA);
    wire idle = (st_ff == ST_IDLE) | (st_ff == ST_DONE);
    wire start = wr & (wb_adr == A_CTRL) & wb_dat_w[C_START] & idle;
    wire [15:0] dll_n = {dll_ff[7:0], db};
    wire [15:0] plen_n = {plen_ff[7:0], db};
    wire streaming = (st_ff == ST_HDR) | (st_ff == ST_PHDR) | (st_ff == ST_PAT) | (st_ff == ST_DEF);
    // oversize defect length goes straight to the checks
    wire def_go = (dll_ff != 16'h0000) & (dll_ff <= DLL_MAX); // RULE10
    wire def_go_n = (dll_n != 16'h0000) & (dll_n <= DLL_MAX); // RULE10

    // descriptor conversion
    wire [63:0] dsc = {dsr_ff, db};
    wire [23:0] d_cyl = dsc[63:40];
    wire [7:0] d_head = dsc[39:32];
    wire [31:0] d_lo = dsc[31:0];
    wire is_bfi = lfmt_ff == LF_BFI;
    wire [31:0] d_sect = is_bfi ? (d_lo >> SECT_SHIFT) : d_lo; // RULE15 RULE16
    wire d_ok = (d_cyl <= maxcyl_ff) & (d_head < heads_ff) & (d_sect < {16'h0000, spt_ff})
        & (~is_bfi | (d_lo < bpt_ff)); // RULE13
    wire [31:0] d_key = {d_cyl[11:0], d_head[3:0], d_sect[15:0]};
    wire dsc_end = (st_ff == ST_DEF) & data_we & (cnt_ff[2:0] == DSC_LAST);

    // whole-list checks
    wire bad_fmt = fmt_data_ff & (lfmt_ff != LF_BFI) & (lfmt_ff != LF_PHYS); // RULE14
    wire bad_len = (dll_ff[2:0] != 3'h0) | (dll_ff > DLL_MAX); // RULE10 RULE11
    wire bad_t0 = (ptype_ff == PT_DEFAULT) & (plen_ff != 16'h0000); // RULE5
    wire bad_t1 = (ptype_ff == PT_USER) & (plen_ff == 16'h0000); // RULE6
    wire bad_pl = (plen_ff > blksz_ff) | (plen_ff > 16'(PAT_DEPTH)) | (ptype_ff > PT_USER); // RULE4
    wire bad = bad_fmt | bad_len | inval_ff | (opts_ff.pat_inc & (bad_t0 | bad_t1 | bad_pl));

    // primary match
    wire [31:0] h_key = hl_mem[cnt_ff[9:0]];
    wire [PL_DEPTH-1:0] pl_hit;
    genvar gi;
    generate
        for (gi = 0; gi < PL_DEPTH; gi++) begin : g_hit
            assign pl_hit[gi] = ((LW+1)'(gi) < pl_cnt_ff) & (pl_mem[gi] == h_key);
        end
    endgenerate
    wire commit_on = (st_ff == ST_COMMIT) & (cnt_ff < {5'h00, hl_cnt_ff});
    wire skip = opts_ff.prim_dis & (|pl_hit); // RULE17 RULE20
    wire gl_add = commit_on & ~skip & (gl_cnt_ff < HL_MAX);
    wire go_fmt = (st_ff == ST_COMMIT) & ~commit_on;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE, ST_DONE: begin
                if (start) begin
                    nxt_st = wb_dat_w[C_FMT_DATA] ? ST_HDR : ST_CHECK; // RULE18
                end
            end
            ST_HDR: begin
                if (data_we & (cnt_ff[1:0] == HDR_LAST)) begin
                    if (opts_ff.pat_inc) begin
                        nxt_st = ST_PHDR; // RULE19
                    end else begin
                        nxt_st = def_go_n ? ST_DEF : ST_CHECK;
                    end
                end
            end
            ST_PHDR: begin
                if (data_we & (cnt_ff[1:0] == HDR_LAST)) begin
                    if (plen_n != 16'h0000) begin
                        nxt_st = ST_PAT;
                    end else begin
                        nxt_st = def_go ? ST_DEF : ST_CHECK;
                    end
                end
            end
            ST_PAT: begin
                if (data_we & (cnt_ff == plen_ff - 16'h0001)) begin
                    nxt_st = def_go ? ST_DEF : ST_CHECK;
                end
            end
            ST_DEF: begin
                if (data_we & (cnt_ff == dll_ff - 16'h0001)) begin
                    nxt_st = ST_CHECK;
                end
            end
            ST_CHECK: nxt_st = bad ? ST_DONE : ST_COMMIT; // RULE21
            ST_COMMIT: begin
                if (go_fmt) begin
                    nxt_st = ST_FORMAT;
                end
            end
            ST_FORMAT: begin
                if (med_done) begin
                    nxt_st = ST_DONE;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    wire adv = (streaming & data_we) | commit_on;
    wire [15:0] nxt_cnt = (nxt_st != st_ff) ? 16'h0000 : cnt_ff + {15'h0000, adv};
    wire set_rdy = ((st_ff == ST_CHECK) & bad) | (go_fmt & opts_ff.immed)
        | ((st_ff == ST_FORMAT) & med_done & ~opts_ff.immed); // RULE8

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= ST_IDLE;
            cnt_ff <= 16'h0000;
            ready_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ready_ff <= ~start & (ready_ff | set_rdy);
        end
    end

    // list fields, back to their reset values at start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            opts_ff <= OPTS_RST;
            pl_use_ff <= 1'b1;
            dll_ff <= 16'h0000;
            plen_ff <= 16'h0000;
            ptype_ff <= 8'h00;
            si_ff <= 1'b0;
        end else if (start) begin
            opts_ff <= OPTS_RST;
            pl_use_ff <= 1'b1;
            dll_ff <= 16'h0000;
            plen_ff <= 16'h0000;
            ptype_ff <= 8'h00;
            si_ff <= 1'b0;
        end else if (data_we & (st_ff == ST_HDR)) begin
            if (cnt_ff[1:0] == 2'h1) begin
                opts_ff <= {db[H_PRIM_DIS], db[H_PAT_INC], db[H_DSP], db[H_IMMED]};
                pl_use_ff <= ~db[H_PRIM_DIS]; // RULE20
            end
            dll_ff <= (cnt_ff[1]) ? dll_n : dll_ff;
        end else if (data_we & (st_ff == ST_PHDR)) begin
            case (cnt_ff[1:0])
                2'h0: si_ff <= db[P_SI]; // RULE2
                2'h1: ptype_ff <= db;
                default: plen_ff <= plen_n;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (data_we & (st_ff == ST_PAT) & (cnt_ff < 16'(PAT_DEPTH))) begin
            pat_mem[cnt_ff[PW-1:0]] <= db;
        end
        if (dsc_end & (hl_cnt_ff < HL_MAX)) begin
            hl_mem[hl_cnt_ff[9:0]] <= d_key; // RULE12
        end
        if (gl_add) begin
            gl_mem[gl_cnt_ff[9:0]] <= h_key;
        end
        if (wr & (wb_adr == A_PLWR) & (pl_cnt_ff < (LW+1)'(PL_DEPTH))) begin
            pl_mem[pl_cnt_ff[LW-1:0]] <= wb_dat_w;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dsr_ff <= 56'h0;
            hl_cnt_ff <= 11'h000;
            inval_ff <= 1'b0;
            gl_cnt_ff <= 11'h000;
            pl_cnt_ff <= '0;
        end else begin
            dsr_ff <= (data_we & (st_ff == ST_DEF)) ? dsc[55:0] : dsr_ff;
            if (start) begin
                hl_cnt_ff <= 11'h000;
                inval_ff <= 1'b0;
            end else if (dsc_end) begin
                hl_cnt_ff <= hl_cnt_ff + {10'h000, hl_cnt_ff < HL_MAX};
                inval_ff <= inval_ff | ~d_ok | (hl_cnt_ff == HL_MAX); // RULE13 RULE10
            end
            gl_cnt_ff <= gl_cnt_ff + {10'h000, gl_add}; // RULE17
            pl_cnt_ff <= pl_cnt_ff + {{LW{1'b0}},
                wr & (wb_adr == A_PLWR) & (pl_cnt_ff < (LW+1)'(PL_DEPTH))};
        end
    end

    // sense and media handoff
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sense_ff <= '0;
            med_start_ff <= 1'b0;
            med_save_ff <= 1'b0;
        end else begin
            med_start_ff <= go_fmt;
            med_save_ff <= go_fmt & ~opts_ff.dsp; // RULE7
            if (start) begin
                sense_ff <= '0;
            end else if ((st_ff == ST_CHECK) & bad) begin
                sense_ff <= {1'b1, 1'b0, SK_ILLEGAL, ASC_INVAL_PL}; // RULE5 RULE6 RULE11
            end else if ((st_ff == ST_FORMAT) & med_done & med_err) begin
                sense_ff <= {1'b1, opts_ff.immed, SK_MEDIUM, ASC_FMT_FAIL}; // RULE9
            end
        end
    end

    // fill byte stream, pattern repeats every pattern length from format start, not restarted per block
    wire fwrap = fptr_ff >= plen_ff - 16'h0001;
    wire [7:0] fsel = ~opts_ff.pat_inc ? FILL_ZERO : (ptype_ff == PT_DEFAULT) ? FILL_DEFAULT
        : pat_mem[fptr_ff[PW-1:0]]; // RULE3 RULE19
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fptr_ff <= 16'h0000;
            fill_ff <= 8'h00;
        end else begin
            if (go_fmt) begin
                fptr_ff <= 16'h0000;
            end else if (med_fill_next) begin
                fptr_ff <= fwrap ? 16'h0000 : fptr_ff + 16'h0001; // RULE3
            end
            fill_ff <= fsel;
        end
    end

    // software registers
    wire [31:0] rd_mux = (wb_adr == A_STAT) ?
            {16'h0000, sense_ff.asc, sense_ff.key, sense_ff.defer, sense_ff.check,
            ready_ff, ~idle} :
        (wb_adr == A_CTRL) ? {27'h0, lfmt_ff, fmt_data_ff, 1'b0} :
        (wb_adr == A_MAXCYL) ? {8'h00, maxcyl_ff} :
        (wb_adr == A_GEOM) ? {spt_ff, 8'h00, heads_ff} :
        (wb_adr == A_BPT) ? bpt_ff :
        (wb_adr == A_BLKSZ) ? {16'h0000, blksz_ff} :
        (wb_adr == A_PLWR) ? 32'(pl_cnt_ff) :
        (wb_adr == A_GLIDX) ? {22'h0, gl_idx_ff} :
        (wb_adr == A_GLDAT) ? gl_mem[gl_idx_ff] :
        (wb_adr == A_GLCNT) ? {21'h0, gl_cnt_ff} : 32'h00000000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_ff <= 1'b0;
            wb_dat_r_ff <= 32'h00000000;
            fmt_data_ff <= 1'b0;
            lfmt_ff <= LF_BFI;
            maxcyl_ff <= MAXCYL_RST;
            heads_ff <= HEADS_RST;
            spt_ff <= SPT_RST;
            bpt_ff <= BPT_RST;
            blksz_ff <= BLKSZ_RST;
            gl_idx_ff <= 10'h000;
        end else begin
            wb_ack_ff <= req;
            wb_dat_r_ff <= (req & ~wb_we) ? rd_mux : 32'h00000000;
            if (start) begin
                fmt_data_ff <= wb_dat_w[C_FMT_DATA];
                lfmt_ff <= wb_dat_w[C_LFMT+2:C_LFMT];
            end
            if (wr & idle) begin
                maxcyl_ff <= (wb_adr == A_MAXCYL) ? wb_dat_w[23:0] : maxcyl_ff;
                heads_ff <= (wb_adr == A_GEOM) ? wb_dat_w[7:0] : heads_ff;
                spt_ff <= (wb_adr == A_GEOM) ? wb_dat_w[31:16] : spt_ff;
                bpt_ff <= (wb_adr == A_BPT) ? wb_dat_w : bpt_ff;
                blksz_ff <= (wb_adr == A_BLKSZ) ? wb_dat_w[15:0] : blksz_ff;
            end
            gl_idx_ff <= (wr & (wb_adr == A_GLIDX)) ? wb_dat_w[9:0] : gl_idx_ff;
        end
    end

    assign wb_ack = wb_ack_ff;
    assign wb_dat_r = wb_dat_r_ff;
    assign med_start = med_start_ff;
    assign med_save = med_save_ff;
    assign med_si = si_ff;
    assign med_pl_use = pl_use_ff;
    assign med_fill = fill_ff;

    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_reject;
        (st_ff == ST_DONE) && sense_ff.check && (sense_ff.key == SK_ILLEGAL)
            && (sense_ff.asc == ASC_INVAL_PL);
    endsequence
    sequence s_launch;
        med_start_ff && (st_ff == ST_FORMAT);
    endsequence
    property p_t0_len;
        (st_ff == ST_CHECK) && opts_ff.pat_inc && (ptype_ff == PT_DEFAULT)
            && (plen_ff != 16'h0000) |=> s_reject;
    endproperty
    a_t0_len: assert property (p_t0_len) else $error("type 0 with length not rejected"); // RULE5
    property p_t1_len;
        (st_ff == ST_CHECK) && opts_ff.pat_inc && (ptype_ff == PT_USER)
            && (plen_ff == 16'h0000) |=> s_reject;
    endproperty
    a_t1_len: assert property (p_t1_len) else $error("type 1 zero length not rejected"); // RULE6
    property p_dll;
        (st_ff == ST_CHECK) && (dll_ff[2:0] != 3'h0) |=> s_reject;
    endproperty
    a_dll: assert property (p_dll) else $error("odd defect list length accepted"); // RULE11
    property p_block;
        (st_ff == ST_CHECK) && fmt_data_ff && (lfmt_ff == LF_BLOCK) |=> s_reject;
    endproperty
    a_block: assert property (p_block) else $error("block format accepted"); // RULE14
    property p_untouched;
        (st_ff == ST_CHECK) && bad |=> $stable(gl_cnt_ff) && !med_start_ff ##1 !med_start_ff;
    endproperty
    a_untouched: assert property (p_untouched) else $error("rejected list changed state"); // RULE21
    property p_immed;
        go_fmt && opts_ff.immed |=> s_launch and ready_ff;
    endproperty
    a_immed: assert property (p_immed) else $error("immediate status late"); // RULE8
    property p_wait;
        (st_ff == ST_FORMAT) && !opts_ff.immed |-> !ready_ff;
    endproperty
    a_wait: assert property (p_wait) else $error("status before format end"); // RULE8
    property p_defer;
        (st_ff == ST_FORMAT) && opts_ff.immed && med_done && med_err
            |=> sense_ff.defer && sense_ff.check && (st_ff == ST_DONE);
    endproperty
    a_defer: assert property (p_defer) else $error("deferred error missing"); // RULE9
    property p_save;
        go_fmt |=> s_launch and (med_save_ff == !opts_ff.dsp);
    endproperty
    a_save: assert property (p_save) else $error("save request wrong"); // RULE7
    property p_skip;
        commit_on && skip |=> $stable(gl_cnt_ff);
    endproperty
    a_skip: assert property (p_skip) else $error("primary entry added to grown"); // RULE17
endmodule

// [test/fpc_media_model.sv]
// fpc_media_model: behavioural media engine on the far side of the checker.
// assumes: shares clk and rst_b; answers each start after a fixed delay.
`timescale 1ns/100ps
module fpc_media_model #(
    parameter int DLY = 20
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic med_start,
    input wire logic err_mode,
    output logic med_done,
    output logic med_err,
    output logic med_fill_next
);
    int cnt;
    // error flag only meaningful with done; otherwise shows the opposite value
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            med_done <= 1'b0;
            med_err <= 1'b0;
            med_fill_next <= 1'b0;
        end else begin
            med_done <= (cnt == 1);
            med_err <= (cnt == 1) ? err_mode : ~err_mode;
            med_fill_next <= (cnt > 1) && (cnt < 5);
            if (med_start)
                cnt <= DLY;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule

// [test/tb.sv]
// tb: scenario tests of the format parameter list checker.
// assumes: classic Wishbone master in the bench, media model on the far side.
`timescale 1ns/100ps
module tb;
    import fpc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0;
    logic [31:0] rd;
    logic ack, m_done, m_err, m_next, m_start, m_si, m_save, m_pl, err_mode = 1'b0;
    logic [7:0] m_fill;
    logic save_c, si_c, pl_c, st_d = 1'b0;
    logic [7:0] fill_c;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_start = 0;
    fpc_checker dut_u (.clk(clk), .rst_b(rst_b), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
        .wb_adr(adr), .wb_sel(4'hF), .wb_dat_w(dw), .wb_dat_r(rd), .wb_ack(ack),
        .med_done(m_done), .med_err(m_err), .med_fill_next(m_next), .med_start(m_start),
        .med_si(m_si), .med_save(m_save), .med_pl_use(m_pl), .med_fill(m_fill));
    fpc_media_model model_u (.clk(clk), .rst_b(rst_b), .med_start(m_start),
        .err_mode(err_mode), .med_done(m_done), .med_err(m_err), .med_fill_next(m_next));
    initial begin
        forever #50 clk = ~clk;
    end
    // capture media flags at each start, fill byte one cycle later
    always @(posedge clk) begin
        if (st_d)
            fill_c = m_fill;
        st_d = (m_start === 1'b1);
        if (st_d) begin
            n_start++;
            save_c = m_save;
            si_c = m_si;
            pl_c = m_pl;
        end
    end
    task automatic stop_test();
        $display("mismatches %0d of %0d compares", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic send(input logic [31:0] c, input logic [7:0] b[$]);
        wr(A_CTRL, c);
        foreach (b[i])
            wr(A_DATA, {24'h0, b[i]});
    endtask
    task automatic poll(input int bit_n, input logic v, output logic [31:0] q);
        do begin
            wb(1'b0, A_STAT, 32'h0, q);
        end while (q[bit_n] !== v);
    endtask
    task automatic wait_n(input int k);
        while (n_start < k) begin
            @(posedge clk);
        end
        @(posedge clk);
        @(posedge clk);
    endtask
    task automatic t_plain();
        logic [31:0] q;
        wr(A_CTRL, 32'h1);
        wait_n(1);
        check(32'({save_c, pl_c, fill_c}), 32'h100);
        wb(1'b0, A_STAT, 32'h0, q);
        check(32'(q[1:0]), 32'h1);
        poll(0, 1'b0, q);
        check(32'(q[15:0]), 32'h2);
    endtask
    task automatic t_reject(input logic [31:0] c, input logic [7:0] b[$]);
        logic [31:0] q;
        logic [31:0] g;
        logic [31:0] g2;
        int k;
        k = n_start;
        wb(1'b0, A_GLCNT, 32'h0, g);
        send(c, b);
        poll(1, 1'b1, q);
        check(32'(q[15:1]), 32'h132B);
        repeat (10) @(posedge clk);
        wb(1'b0, A_GLCNT, 32'h0, g2);
        check(g2 - g + 32'(n_start - k), 32'h0);
    endtask
    task automatic t_defects();
        logic [31:0] q;
        logic [31:0] g;
        logic [31:0] g2;
        logic [7:0] b[$];
        b = '{8'h00, 8'h4A, 8'h00, 8'h18, 8'h20, 8'h01, 8'h00, 8'h02, 8'hAA, 8'h55,
              8'h00, 8'h00, 8'h09, 8'h01, 8'h00, 8'h00, 8'h00, 8'h03,
              8'h00, 8'h00, 8'h05, 8'h02, 8'h00, 8'h00, 8'h00, 8'h07,
              8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
        err_mode <= 1'b1;
        wr(A_PLWR, 32'h00520007);
        wb(1'b0, A_GLCNT, 32'h0, g);
        send(32'h17, b);
        wait_n(2);
        check(32'({save_c, pl_c, si_c, fill_c}), 32'h5AA);
        wb(1'b0, A_STAT, 32'h0, q);
        check(32'(q[1:0]), 32'h3);
        poll(0, 1'b0, q);
        check(32'(q[15:3]), 32'h627);
        wb(1'b0, A_GLCNT, 32'h0, g2);
        check(g2 - g, 32'h2);
        err_mode <= 1'b0;
    endtask
    task automatic t_bfi();
        logic [31:0] q;
        logic [31:0] g;
        wb(1'b0, A_GLCNT, 32'h0, g);
        send(32'h13, '{8'h00, 8'h04, 8'h00, 8'h08,
                       8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00, 8'h34, 8'h56});
        wait_n(3);
        check(32'(save_c), 32'h0);
        poll(0, 1'b0, q);
        check(32'(q[15:0]), 32'h2);
        wr(A_GLIDX, g);
        wb(1'b0, A_GLDAT, 32'h0, q);
        check(q, 32'h00310003);
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_plain();
        t_reject(32'h17, '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                           8'hAA});
        t_reject(32'h17, '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00});
        t_reject(32'h03, '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01});
        t_reject(32'h17, '{8'h00, 8'h00, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h01, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
        t_reject(32'h17, '{8'h00, 8'h00, 8'h00, 8'h08, 8'h01, 8'h00, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h00});
        t_reject(32'h17, '{8'h00, 8'h00, 8'h20, 8'h08});
        t_defects();
        t_bfi();
        stop_test();
    end
endmodule
